// ==== design/wwdt_top.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Contract
// - command 0x00, configuration 0x04, status 0x08
// - configuration resets 0x3FFF_2FFF, written only once
// - bit 0 set with key restarts
// - key byte must be 0xA5, else ignored
// - bits 11..0 give counter load value
// - fault interrupt enable gates interrupt output
// - reset enable gates fault toward reset
// - bit 14 limits reset to processor
// - restart allowed when counter within window
// - restart above window is window error
// - debug halt stops counter in debug
// - idle halt stops counter while idle
// - disable bit stops the timer
// - status bit 0 flags underflow since read
// - status bit 1 flags window error
// - tick is slow clock over 128, restart clears
// - configuration write reloads and restarts counter
// - underflow sets flag and asserts fault
// - status read clears flags, interrupt, fault
module wwdt_top
	import wwdt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic slow_clk,
	input wire logic cpu_debug,
	input wire logic cpu_idle,
	output logic fault_irq,
	output logic fault_reset,
	output logic fault_proc_only
);

	logic slow_s1_r, slow_s2_r, slow_s3_r;
	logic dbg_s1_r, dbg_s2_r, idle_s1_r, idle_s2_r;
	logic aw_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic w_held_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [31:0] cfg_r;
	logic [31:0] cfg_nxt;
	logic cfg_locked_r;
	logic [CNT_W-1:0] cnt_r;
	logic unf_r;
	logic err_r;
	logic fault_r;
	logic proc_only_r;
	logic irq_r;
	logic [31:0] byte_mask;
	logic [31:0] wd_masked;
	logic wr_do;
	logic rd_do;
	logic cmd_hit;
	logic restart_req, restart_ok, win_err;
	logic cfg_wr;
	logic stat_rd;
	logic in_window;
	logic run;
	logic slow_edge;
	logic tick;
	logic underflow;
	logic fault_evt;
	logic [CNT_W-1:0] load_val;
	logic [CNT_W-1:0] win_limit;

	// pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_s1_r <= 1'b0;
			slow_s2_r <= 1'b0;
			slow_s3_r <= 1'b0;
			dbg_s1_r <= 1'b0;
			dbg_s2_r <= 1'b0;
			idle_s1_r <= 1'b0;
			idle_s2_r <= 1'b0;
		end else begin
			slow_s1_r <= slow_clk;
			slow_s2_r <= slow_s1_r;
			slow_s3_r <= slow_s2_r;
			dbg_s1_r <= cpu_debug;
			dbg_s2_r <= dbg_s1_r;
			idle_s1_r <= cpu_idle;
			idle_s2_r <= idle_s1_r;
		end
	end

	assign slow_edge = slow_s2_r && !slow_s3_r;

	// write channels: address and data taken in either order
	assign awready = !aw_held_r && !bvalid_r;
	assign wready = !w_held_r && !bvalid_r;
	assign wr_do = aw_held_r && w_held_r && !bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= awaddr;
		end else if (wr_do) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			w_data_r <= wdata;
			w_strb_r <= wstrb;
		end else if (wr_do) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			if (aw_addr_r == OFF_CMD || aw_addr_r == OFF_CFG) begin
				bresp_r <= RESP_OKAY;
			end else begin
				bresp_r <= RESP_DECERR;
			end
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	// lanes not strobed count as zero
	assign byte_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wd_masked = w_data_r & byte_mask;

	assign cmd_hit = wr_do && (aw_addr_r == OFF_CMD);
	assign restart_req = cmd_hit && (wd_masked[CMD_KEY_LSB +: 8] == CMD_KEY_VALUE)
		&& wd_masked[CMD_RESTART_BIT];
	assign cfg_wr = wr_do && (aw_addr_r == OFF_CFG) && !cfg_locked_r;
	assign cfg_nxt = (cfg_r & ~byte_mask) | wd_masked;

	// window check, even while disabled
	assign load_val = cfg_r[CFG_LOAD_LSB +: CNT_W];
	assign win_limit = cfg_r[CFG_WIN_LSB +: CNT_W];
	assign in_window = cnt_r <= win_limit;
	assign restart_ok = restart_req && in_window;
	assign win_err = restart_req && !in_window;

	// read channel
	assign arready = !rvalid_r;
	assign rd_do = arvalid && arready;
	assign stat_rd = rd_do && (araddr == OFF_STAT);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (rd_do) begin
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
			if (araddr == OFF_CFG) begin
				rdata_r <= cfg_r;
			end else if (araddr == OFF_STAT) begin
				rdata_r <= {30'h0, err_r, unf_r};
			end else if (araddr != OFF_CMD) begin
				rresp_r <= RESP_DECERR;
			end
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// configuration, locked after the first accepted write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= CFG_RESET;
			cfg_locked_r <= 1'b0;
		end else if (cfg_wr) begin
			cfg_r <= cfg_nxt;
			cfg_locked_r <= 1'b1;
		end
	end

	assign run = !cfg_r[CFG_OFF_BIT]
		&& !(cfg_r[CFG_DBG_BIT] && dbg_s2_r)
		&& !(cfg_r[CFG_IDLE_BIT] && idle_s2_r);

	wwdt_prescaler #(
		.DIV_W(PRESC_W)
	) u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(restart_ok || cfg_wr),
		.step(slow_edge && run),
		.tick(tick)
	);

	assign underflow = tick && (cnt_r == '0);
	assign fault_evt = underflow || win_err;

	// down counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= CFG_RESET[CFG_LOAD_LSB +: CNT_W];
		end else if (cfg_wr) begin
			cnt_r <= cfg_nxt[CFG_LOAD_LSB +: CNT_W];
		end else if (restart_ok) begin
			cnt_r <= load_val;
		end else if (underflow) begin
			cnt_r <= load_val;
		end else if (tick) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unf_r <= STAT_RESET[STAT_UNF_BIT];
		end else if (underflow) begin
			unf_r <= 1'b1;
		end else if (stat_rd) begin
			unf_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_r <= STAT_RESET[STAT_ERR_BIT];
		end else if (win_err) begin
			err_r <= 1'b1;
		end else if (stat_rd) begin
			err_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_r <= 1'b0;
			proc_only_r <= 1'b0;
		end else if (fault_evt && cfg_r[CFG_RSTEN_BIT]) begin
			fault_r <= 1'b1;
			proc_only_r <= cfg_r[CFG_PROC_BIT];
		end else if (stat_rd) begin
			fault_r <= 1'b0;
			proc_only_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_r <= 1'b0;
		end else if (fault_evt && cfg_r[CFG_FIEN_BIT]) begin
			irq_r <= 1'b1;
		end else if (stat_rd) begin
			irq_r <= 1'b0;
		end
	end

	assign fault_irq = irq_r;
	assign fault_reset = fault_r;
	assign fault_proc_only = proc_only_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_restart_in;
		restart_req && in_window;
	endsequence

	sequence s_restart_out;
		restart_req && !in_window;
	endsequence

	sequence s_clean_read;
		stat_rd && !underflow && !win_err;
	endsequence

	property p_cfg_once;
		cfg_locked_r && !cfg_wr |=> $stable(cfg_r) && cfg_locked_r;
	endproperty
	a_cfg_once: assert property (p_cfg_once) else $error("configuration changed after lock");

	property p_bad_key;
		cmd_hit && (wd_masked[CMD_KEY_LSB +: 8] != CMD_KEY_VALUE) |=> !$rose(err_r);
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("restart taken with wrong key");

	property p_restart_reload;
		s_restart_in ##0 !cfg_wr |=> cnt_r == $past(load_val);
	endproperty
	a_restart_reload: assert property (p_restart_reload) else $error("restart did not reload");

	property p_window_error;
		s_restart_out |=> err_r ##1 1'b1;
	endproperty
	a_window_error: assert property (p_window_error) else $error("window error not flagged");

	property p_underflow_flag;
		underflow |=> unf_r && cnt_r == $past(load_val);
	endproperty
	a_underflow_flag: assert property (p_underflow_flag) else $error("underflow not flagged");

	property p_read_clears;
		s_clean_read |=> !unf_r && !err_r && !fault_r && !irq_r;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read left flags set");

	property p_irq_gate;
		$rose(irq_r) |-> $past(cfg_r[CFG_FIEN_BIT]) && (unf_r || err_r);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

	property p_reset_gate;
		$rose(fault_r) |-> $past(cfg_r[CFG_RSTEN_BIT]);
	endproperty
	a_reset_gate: assert property (p_reset_gate) else $error("fault without reset enable");

	property p_disabled_hold;
		cfg_r[CFG_OFF_BIT] && !restart_ok && !cfg_wr |=> $stable(cnt_r);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("disabled counter moved");

	property p_debug_hold;
		cfg_r[CFG_DBG_BIT] && dbg_s2_r && !restart_ok && !cfg_wr |=> $stable(cnt_r);
	endproperty
	a_debug_hold: assert property (p_debug_hold) else $error("counter ran in debug halt");

endmodule

// ==== include/wwdt_pkg.sv ====
package wwdt_pkg;

	// bus geometry
	localparam int ADDR_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CMD = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CFG = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;

	// restart command fields
	localparam int CMD_RESTART_BIT = 0;
	localparam int CMD_KEY_LSB = 24;
	localparam logic [7:0] CMD_KEY_VALUE = 8'hA5;

	// configuration fields
	localparam int CNT_W = 12;
	localparam int CFG_LOAD_LSB = 0;
	localparam int CFG_FIEN_BIT = 12;
	localparam int CFG_RSTEN_BIT = 13;
	localparam int CFG_PROC_BIT = 14;
	localparam int CFG_OFF_BIT = 15;
	localparam int CFG_WIN_LSB = 16;
	localparam int CFG_DBG_BIT = 28;
	localparam int CFG_IDLE_BIT = 29;
	localparam logic [31:0] CFG_RESET = 32'h3FFF_2FFF;

	// status fields
	localparam int STAT_UNF_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam logic [31:0] STAT_RESET = 32'h0000_0000;

	// slow clock prescaler: divide by 128
	localparam int PRESC_DIV = 128;
	localparam int PRESC_W = $clog2(PRESC_DIV);

endpackage

// ==== design/wwdt_prescaler.sv ====
`timescale 1ns/1ps

// counts slow clock edges, one tick every 2**DIV_W edges
module wwdt_prescaler #(
	parameter int DIV_W = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic step,
	output logic tick
);

	logic [DIV_W-1:0] count_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			count_r <= '0;
		end else if (step) begin
			count_r <= count_r + 1'b1;
		end
	end

	assign tick = step && (count_r == {DIV_W{1'b1}}) && !clear;

endmodule

// ==== verification/wwdt_sys_model.sv ====
`timescale 1ns/1ps
// slow oscillator and reset controller stand-in
module wwdt_sys_model (
	input wire logic aclk,
	input wire logic fault_reset,
	input wire logic fault_proc_only,
	output logic slow_clk,
	output int proc_rsts,
	output int all_rsts
);
	logic seen_r;
	initial begin
		slow_clk = 1'h0;
		proc_rsts = 0;
		all_rsts = 0;
		seen_r = 1'h0;
	end
	// slow clock at half the bus rate
	always @(posedge aclk) begin
		slow_clk <= !slow_clk;
	end
	// counts fault requests by reset scope
	always @(posedge aclk) begin
		seen_r <= fault_reset;
		if (fault_reset && !seen_r && fault_proc_only) begin
			proc_rsts <= proc_rsts + 1;
		end
		if (fault_reset && !seen_r && !fault_proc_only) begin
			all_rsts <= all_rsts + 1;
		end
	end
endmodule

// ==== verification/wwdt_tb_top.sv ====
`timescale 1ns/1ps
module wwdt_tb_top
	import wwdt_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic cpu_debug = 1'h0;
	logic cpu_idle = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, slow_clk;
	logic fault_irq, fault_reset, fault_proc_only;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int proc_rsts, all_rsts, t;
	int error_cnt = 0;
	int checks = 0;
	localparam logic [31:0] GO = 32'hA500_0001;
	always #10 aclk = !aclk;

	wwdt_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .slow_clk(slow_clk), .cpu_debug(cpu_debug), .cpu_idle(cpu_idle),
		.fault_irq(fault_irq), .fault_reset(fault_reset), .fault_proc_only(fault_proc_only));
	wwdt_sys_model sys_u (.aclk(aclk), .fault_reset(fault_reset), .fault_proc_only(fault_proc_only),
		.slow_clk(slow_clk), .proc_rsts(proc_rsts), .all_rsts(all_rsts));

	task automatic conclude;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rst;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
	endtask

	// ready sampled at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ka, kw, kb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge aclk);
			ka = awready;
			kw = wready;
			kb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ka) awvalid <= 1'h0;
			if (kw) wvalid <= 1'h0;
		end while (!kb);
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge aclk);
			k = arready;
			@(posedge aclk);
		end while (!k);
		arvalid <= 1'h0;
		do begin
			@(negedge aclk);
			k = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end while (!k);
		rready <= 1'h0;
	endtask

	task automatic wk(input logic [3:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, RESP_OKAY);
	endtask

	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask

	// cycles until a fault output shows, at most n
	task automatic waitf(input int n);
		t = 0;
		while (t < n && fault_irq !== 1'h1 && fault_reset !== 1'h1) begin
			@(negedge aclk);
			t++;
		end
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rc(OFF_CFG, CFG_RESET);
		rc(OFF_STAT, STAT_RESET);
		rc(OFF_CMD, 32'h0);
		rd(4'hC, d, r);
		chk(r, RESP_DECERR);
		wr(4'hC, 32'h0, r);
		chk(r, RESP_DECERR);
		$display("reset test done");
	endtask

	task automatic t_under;
		rst;
		cpu_debug <= 1'h1;
		cpu_idle <= 1'h1;
		wk(OFF_CFG, 32'h0002_7002);
		rc(OFF_CFG, 32'h0002_7002);
		wk(OFF_CFG, 32'h0000_0FFF);
		rc(OFF_CFG, 32'h0002_7002);
		waitf(900);
		chk(t > 700 && t < 800, 32'h1);
		chk({fault_irq, fault_reset, fault_proc_only}, 32'h7);
		rc(OFF_STAT, 32'h1);
		chk(proc_rsts, 32'h1);
		@(negedge aclk);
		chk({fault_irq, fault_reset}, 32'h0);
		rc(OFF_STAT, 32'h0);
		waitf(900);
		chk(t > 650 && t < 800, 32'h1);
		$display("underflow test done");
	endtask

	task automatic t_window;
		rst;
		wk(OFF_CFG, 32'h0002_1100);
		wk(OFF_CMD, 32'h5A00_0001);
		wk(OFF_CMD, 32'hA500_0000);
		wstrb <= 4'h1;
		wk(OFF_CMD, GO);
		wstrb <= 4'hF;
		@(negedge aclk);
		chk(fault_irq, 32'h0);
		wk(OFF_CMD, GO);
		@(negedge aclk);
		chk({fault_irq, fault_reset}, 32'h2);
		rc(OFF_STAT, 32'h2);
		$display("window test done");
	endtask

	task automatic t_restart;
		rst;
		wk(OFF_CFG, 32'h0002_1002);
		repeat (3) begin
			repeat (400) @(posedge aclk);
			wk(OFF_CMD, GO);
		end
		waitf(700);
		chk(t, 32'd700);
		rc(OFF_STAT, 32'h0);
		waitf(200);
		chk(t < 200, 32'h1);
		$display("restart test done");
	endtask

	task automatic t_halt;
		rst;
		cpu_debug <= 1'h1;
		cpu_idle <= 1'h0;
		wk(OFF_CFG, 32'h3002_1002);
		waitf(1000);
		chk(t, 32'd1000);
		@(posedge aclk);
		cpu_debug <= 1'h0;
		cpu_idle <= 1'h1;
		waitf(1000);
		chk(t, 32'd1000);
		@(posedge aclk);
		cpu_idle <= 1'h0;
		waitf(1000);
		chk(t < 1000, 32'h1);
		rst;
		wk(OFF_CFG, 32'h0002_9002);
		waitf(1500);
		chk(t, 32'd1500);
		$display("halt test done");
	endtask

	task automatic t_all;
		rst;
		wk(OFF_CFG, 32'h0002_2002);
		waitf(900);
		chk({fault_irq, fault_reset, fault_proc_only}, 32'h2);
		rst;
		@(negedge aclk);
		chk(fault_reset, 32'h0);
		chk(all_rsts, 32'h1);
		$display("full reset test done");
	endtask

	initial begin
		rst;
		t_reset;
		t_under;
		t_window;
		t_restart;
		t_halt;
		t_all;
		conclude;
	end

	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		$display("Error t=%0t watchdog expired", $time);
		conclude;
	end
endmodule
